// File: bench/fdsa_master.sv
// read master model standing in for the serial slave in front of the status bank
`timescale 1ns/100ps
module fdsa_master (
  // clock
  input  wire logic        mclk,
  // input register read port
  output logic             rd_en,
  output logic      [15:0] rd_addr,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        rd_err
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 16'h0000;
  end
  // one read of a 16-bit input register, no write path exists
  // the index is inverted once released so a stale index cannot pass
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
    int n;
    logic got;
    d = 'x;
    e = 1'bx;
    got = 1'b0;
    @(negedge mclk);
    rd_en = 1'b1;
    rd_addr = a;
    for (n = 0; n < 3; n++) begin
      @(posedge mclk);
      #1;
      if (rd_valid === 1'b1 && !got) begin
        d = rd_data;
        e = rd_err;
        got = 1'b1;
      end
      @(negedge mclk);
      rd_en = 1'b0;
      rd_addr = ~a;
    end
  endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the fan drive status bank and alarm handling
`timescale 1ns/100ps
module tb_top;
  logic        mclk, rst, rd_en, rd_valid, rd_err, driver_on;
  logic        fault_mem, fault_short, fault_sync, reset_cmd, bus_activity;
  logic        fan_run, derate, led, dout;
  logic [1:0]  dout_mode;
  logic [2:0]  fault_class;
  logic [7:0]  fault_detail;
  logic [15:0] rd_addr, rd_data, min_speed, max_speed, target_speed, max_current;
  logic [15:0] max_power, comm_timeout_s, speed_meas, bus_voltage, current_peak;
  logic [15:0] voltage_peak, analog_in, temperature, power_meas;
  int          fail_count = 0;
  int          checked = 0;

  fdsa_top #(.TICK_CYC(10), .RESTART_MS(5), .DERATE_MS(5)) fdsa_top_inst (
    .mclk(mclk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_err(rd_err), .min_speed(min_speed), .max_speed(max_speed),
    .target_speed(target_speed), .max_current(max_current), .max_power(max_power),
    .comm_timeout_s(comm_timeout_s), .dout_mode(dout_mode), .driver_on(driver_on),
    .speed_meas(speed_meas), .bus_voltage(bus_voltage), .current_peak(current_peak),
    .voltage_peak(voltage_peak), .analog_in(analog_in), .temperature(temperature),
    .power_meas(power_meas), .fault_mem(fault_mem), .fault_short(fault_short),
    .fault_sync(fault_sync), .reset_cmd(reset_cmd), .bus_activity(bus_activity),
    .fan_run(fan_run), .derate(derate), .led(led), .dout(dout),
    .fault_class(fault_class), .fault_detail(fault_detail));

  fdsa_master fdsa_master_inst (
    .mclk(mclk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_err(rd_err));

  always #5 mclk = ~mclk;

  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic alarm(input logic [2:0] c, input logic [7:0] d, input logic run);
    chk("fault_class", {13'h0, fault_class}, {13'h0, c});
    chk("fault_detail", {8'h0, fault_detail}, {8'h0, d});
    chk("fan_run", {15'h0, fan_run}, {15'h0, run});
    chk("dout", {15'h0, dout}, {15'h0, c != 3'h0});
  endtask

  task automatic pulse_reset_cmd();
    @(negedge mclk);
    reset_cmd = 1'b1;
    @(negedge mclk);
    reset_cmd = 1'b0;
    edges(2);
  endtask

  // rising edges of the led over one whole frame: one per blink whatever the phase
  task automatic count_led(input int exp);
    int n;
    logic last;
    n = 0;
    last = led;
    repeat (10000) begin
      @(posedge mclk);
      #1;
      if (led === 1'b1 && last !== 1'b1) n++;
      last = led;
    end
    @(negedge mclk);
    chk("led blinks", 16'(n), 16'(exp));
  endtask

  task automatic t_regs();
    logic [15:0] a [13] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h9, 16'ha, 16'hc, 16'hd,
                            16'he, 16'hf, 16'h11, 16'h1f, 16'h4};
    logic [15:0] x [13] = '{fdsa_pkg::FW_REVISION, fdsa_pkg::DRIVER_ID, 16'h03e8,
                            16'h0bb8, 16'h0, 16'h0, 16'h0dac, fdsa_pkg::VOLT_MAX,
                            fdsa_pkg::ANALOG_MAX, 16'h01f4, 16'h0, 16'h0834, 16'h0};
    logic [15:0] d;
    logic        e;
    for (int i = 0; i < 13; i++) begin
      fdsa_master_inst.rd(a[i], d, e);
      chk($sformatf("reg %h", a[i]), d, x[i]);
      chk($sformatf("err %h", a[i]), {15'h0, e}, {15'h0, i == 12});
    end
    driver_on = 1'b1;
    fdsa_master_inst.rd(16'h9, d, e);
    chk("bus voltage on", d, 16'h0fa0);
    driver_on = 1'b0;
    target_speed = 16'h03f0;
    edges(200);
    fdsa_master_inst.rd(16'h2, d, e);
    chk("ramped reference", d, 16'h03f0);
    alarm(3'h0, 8'h00, 1'b1);
    $display("test registers done");
  endtask

  task automatic t_latch();
    logic [15:0] d;
    logic        e;
    for (int c = 1; c <= 2; c++) begin
      @(negedge mclk);
      fault_mem = (c == 1);
      fault_short = (c == 2);
      edges(1);
      alarm(3'(c), 8'h00, 1'b0);
      fdsa_master_inst.rd(16'ha, d, e);
      chk("fault_class reg", d, 16'(c));
      fdsa_master_inst.rd(16'h11, d, e);
      chk("fault_detail reg", d, 16'h0);
      pulse_reset_cmd();
      alarm(3'(c), 8'h00, 1'b0);
      dout_mode = 2'h0;
      edges(2);
      chk("dout other mode", {15'h0, dout}, 16'h0);
      dout_mode = fdsa_pkg::DOUT_ALARM;
      fault_mem = 1'b0;
      fault_short = 1'b0;
      edges(20);
      alarm(3'(c), 8'h00, 1'b0);
      pulse_reset_cmd();
      alarm(3'h0, 8'h00, 1'b1);
    end
    $display("test latching done");
  endtask

  task automatic t_sync();
    @(negedge mclk);
    fault_sync = 1'b1;
    edges(1);
    fault_sync = 1'b0;
    alarm(3'h3, 8'h00, 1'b0);
    edges(35);
    alarm(3'h3, 8'h00, 1'b0);
    edges(35);
    alarm(3'h0, 8'h00, 1'b1);
    $display("test self recovering done");
  endtask

  task automatic t_hot();
    @(negedge mclk);
    temperature = 16'h0320;
    edges(2);
    chk("derate", {15'h0, derate}, 16'h1);
    edges(70);
    alarm(3'h4, fdsa_pkg::DET_OVT, 1'b0);
    temperature = 16'h02bc;
    edges(2);
    chk("derate", {15'h0, derate}, 16'h0);
    chk("fault_class", {13'h0, fault_class}, 16'h0);
    temperature = 16'h01f4;
    edges(80);
    $display("test overtemperature done");
  endtask

  task automatic t_comm();
    @(negedge mclk);
    bus_activity = 1'b1;
    comm_timeout_s = 16'h0001;
    @(negedge mclk);
    bus_activity = 1'b0;
    edges(10200);
    alarm(3'h4, fdsa_pkg::DET_COMM, 1'b0);
    count_led(4);
    alarm(3'h4, fdsa_pkg::DET_COMM, 1'b0);
    comm_timeout_s = 16'h0000;
    pulse_reset_cmd();
    alarm(3'h0, 8'h00, 1'b1);
    count_led(1);
    $display("test link timeout done");
  endtask

  // a reset stands for a power cycle and must drop a latched stop
  task automatic t_power();
    @(negedge mclk);
    fault_short = 1'b1;
    edges(1);
    fault_short = 1'b0;
    alarm(3'h2, 8'h00, 1'b0);
    rst = 1'b1;
    edges(10);
    rst = 1'b0;
    edges(2);
    alarm(3'h0, 8'h00, 1'b1);
    $display("test power cycle done");
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {driver_on, fault_mem, fault_short, fault_sync, reset_cmd, bus_activity} = '0;
    dout_mode = fdsa_pkg::DOUT_ALARM;
    comm_timeout_s = 16'h0000;
    min_speed = 16'h03e8;
    max_speed = 16'h0bb8;
    target_speed = 16'h03e8;
    speed_meas = 16'h0fa0;
    bus_voltage = 16'h0fa0;
    max_current = 16'h0dac;
    current_peak = 16'h1000;
    voltage_peak = 16'h0900;
    analog_in = 16'h0070;
    temperature = 16'h01f4;
    max_power = 16'h0834;
    power_meas = 16'h0900;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    edges(3);
    t_regs();
    t_latch();
    t_sync();
    t_hot();
    t_comm();
    t_power();
    test_done();
  end

  // the tests take about 31000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule

// File: design/fdsa_pkg.sv
// package: constants for the fan drive status register bank and alarm handling
// Operation
// - input register 0 reads the firmware revision, five or greater
// - input register 1 reads a fixed driver identification code
// - register 2 holds speed reference: minimum at start, then ramps to target
// - register 3 reads measured speed, clamped to the maximum speed
// - register 9 reads bus voltage in 0.1 V, zero while driver off
// - fault class register holds 0 to 4, read with the detail code
// - register 17 holds the fault detail 0 to 255, read with the class
// - register 12 reads peak current in mA, clamped to maximum current
// - motor voltage register reads peak phase voltage, at most 2250
// - analog level register reads 0 to 100 tenths of a volt
// - above 75 degrees the drive derates until the temperature drops
// - if derating fails, stop and alarm; clear alarm below 75 degrees
// - register 31 reads absorbed power in W, clamped to maximum power
// - latching stop halts at once; restart on reset command or power cycle
// - self-recovering stop signals alarm, then restarts after a delay
// - every alarm shows in both fault registers, the led and the output
// - with no fault both fault registers read zero, no action taken
// - detail 0: class 1 memory, 2 short latch; class 3 sync recovers
// - communication timeout stops fan, detail 0xff, needs reset command
// - output in alarm mode is low normally, high while an alarm stands
package fdsa_pkg;
  // register indices
  localparam logic [15:0] IDX_FW      = 16'h0000;
  localparam logic [15:0] IDX_ID      = 16'h0001;
  localparam logic [15:0] IDX_SPD_REF = 16'h0002;
  localparam logic [15:0] IDX_SPEED   = 16'h0003;
  localparam logic [15:0] IDX_BUS_V   = 16'h0009;
  localparam logic [15:0] IDX_CLASS   = 16'h000a;
  localparam logic [15:0] IDX_CURRENT = 16'h000c;
  localparam logic [15:0] IDX_VOLTAGE = 16'h000d;
  localparam logic [15:0] IDX_ANALOG  = 16'h000e;
  localparam logic [15:0] IDX_TEMP    = 16'h000f;
  localparam logic [15:0] IDX_DETAIL  = 16'h0011;
  localparam logic [15:0] IDX_POWER   = 16'h001f;
  // fixed contents; the identity value is arbitrary
  localparam logic [15:0] FW_REVISION = 16'h0005;
  localparam logic [15:0] DRIVER_ID   = 16'h0a5c;
  // limits in register units
  localparam logic [15:0] VOLT_MAX    = 16'h08ca;
  localparam logic [15:0] ANALOG_MAX  = 16'h0064;
  localparam logic [15:0] TEMP_LIMIT  = 16'h02ee;
  // fault codes
  localparam logic [2:0]  CLS_NONE    = 3'h0;
  localparam logic [2:0]  CLS_MEM     = 3'h1;
  localparam logic [2:0]  CLS_SHORT   = 3'h2;
  localparam logic [2:0]  CLS_SYNC    = 3'h3;
  localparam logic [2:0]  CLS_EXT     = 3'h4;
  localparam logic [7:0]  DET_NONE    = 8'h00;
  localparam logic [7:0]  DET_OVT     = 8'h71;
  localparam logic [7:0]  DET_COMM    = 8'hff;
  localparam logic [1:0]  DOUT_ALARM  = 2'h1;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0]  SLOT_LAST     = 7'h63;
  localparam logic [3:0]  FRAME_LAST    = 4'h9;
  localparam logic [9:0]  SEC_LAST      = 10'h3e7;
  localparam int unsigned RESTART_MS    = 5000;
  localparam int unsigned DERATE_MS     = 30000;
  // alarm states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_LATCH = 2'b01,
    ST_RECOV = 2'b10,
    ST_HOT   = 2'b11
  } fdsa_state_e;
endpackage

// File: design/fdsa_top.sv
// fan drive status register bank with alarm classification and signalling
`timescale 1ns/100ps
module fdsa_top #(
  parameter int unsigned TICK_CYC   = fdsa_pkg::TICK_CYC,
  parameter int unsigned RESTART_MS = fdsa_pkg::RESTART_MS,
  parameter int unsigned DERATE_MS  = fdsa_pkg::DERATE_MS
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // input register read port from the serial slave
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             rd_err,
  // configuration
  input  wire logic [15:0] min_speed,
  input  wire logic [15:0] max_speed,
  input  wire logic [15:0] target_speed,
  input  wire logic [15:0] max_current,
  input  wire logic [15:0] max_power,
  input  wire logic [15:0] comm_timeout_s,
  input  wire logic [1:0]  dout_mode,
  // measurements
  input  wire logic        driver_on,
  input  wire logic [15:0] speed_meas,
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] current_peak,
  input  wire logic [15:0] voltage_peak,
  input  wire logic [15:0] analog_in,
  input  wire logic [15:0] temperature,
  input  wire logic [15:0] power_meas,
  // fault sources and commands
  input  wire logic        fault_mem,
  input  wire logic        fault_short,
  input  wire logic        fault_sync,
  input  wire logic        reset_cmd,
  input  wire logic        bus_activity,
  // drive and alarm outputs
  output logic             fan_run,
  output logic             derate,
  output logic             led,
  output logic             dout,
  output logic      [2:0]  fault_class,
  output logic      [7:0]  fault_detail
);

  typedef struct packed {
    fdsa_pkg::fdsa_state_e st;
    logic [16:0] tick_cnt;
    logic        tick;
    logic [6:0]  slot_ms;
    logic [3:0]  slot;
    logic [9:0]  idle_ms;
    logic [15:0] idle_s;
    logic [15:0] wait_ms;
    logic [15:0] hot_ms;
    logic [2:0]  cls;
    logic [7:0]  det;
    logic [15:0] spd_ref;
    logic        fan_run;
    logic        derate;
    logic        led;
    logic        dout;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_err;
  } fdsa_regs_s;

  localparam logic [16:0] TICK_LAST    = 17'(TICK_CYC - 1);
  localparam logic [15:0] RESTART_LAST = 16'(RESTART_MS - 1);
  localparam logic [15:0] DERATE_LAST  = 16'(DERATE_MS - 1);

  fdsa_regs_s s_reg;
  fdsa_regs_s s_next;
  logic       hot;
  logic       comm_lost;
  logic       latch_flt;
  logic [2:0] latch_cls;
  logic [7:0] latch_det;
  logic [15:0] tgt;

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // blinks per one-second frame: one when healthy, up to four
  function automatic logic [2:0] blinks(input logic [2:0] c);
    blinks = (c >= fdsa_pkg::CLS_SYNC) ? 3'h4 : c + 3'h1;
  endfunction

  always_comb begin
    hot = temperature > fdsa_pkg::TEMP_LIMIT;
    comm_lost = (comm_timeout_s != 16'h0000) && (s_reg.idle_s >= comm_timeout_s);
    latch_flt = fault_mem | fault_short | comm_lost;
    // memory outranks short circuit outranks lost link
    if (fault_mem) begin
      latch_cls = fdsa_pkg::CLS_MEM;
      latch_det = fdsa_pkg::DET_NONE;
    end else if (fault_short) begin
      latch_cls = fdsa_pkg::CLS_SHORT;
      latch_det = fdsa_pkg::DET_NONE;
    end else begin
      latch_cls = fdsa_pkg::CLS_EXT;
      latch_det = fdsa_pkg::DET_COMM;
    end
    if (target_speed < min_speed) begin
      tgt = min_speed;
    end else begin
      tgt = clamp(target_speed, max_speed);
    end

    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.rd_valid = 1'b0;
    s_next.rd_err = 1'b0;

    // millisecond enable
    if (s_reg.tick_cnt == TICK_LAST) begin
      s_next.tick_cnt = 17'h00000;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 17'h00001;
    end

    // led frame: ten slots of 100 ms
    if (s_reg.tick) begin
      if (s_reg.slot_ms == fdsa_pkg::SLOT_LAST) begin
        s_next.slot_ms = 7'h00;
        if (s_reg.slot == fdsa_pkg::FRAME_LAST) begin
          s_next.slot = 4'h0;
        end else begin
          s_next.slot = s_reg.slot + 4'h1;
        end
      end else begin
        s_next.slot_ms = s_reg.slot_ms + 7'h01;
      end
    end

    // idle time on the link; a reset command is traffic too
    if (bus_activity || reset_cmd) begin
      s_next.idle_ms = 10'h000;
      s_next.idle_s = 16'h0000;
    end else if (s_reg.tick && s_reg.idle_s != 16'hffff) begin
      if (s_reg.idle_ms == fdsa_pkg::SEC_LAST) begin
        s_next.idle_ms = 10'h000;
        s_next.idle_s = s_reg.idle_s + 16'h0001;
      end else begin
        s_next.idle_ms = s_reg.idle_ms + 10'h001;
      end
    end

    // time spent derating without relief
    s_next.derate = hot;
    if (!hot) begin
      s_next.hot_ms = 16'h0000;
    end else if (s_reg.tick && s_reg.hot_ms != DERATE_LAST) begin
      s_next.hot_ms = s_reg.hot_ms + 16'h0001;
    end

    case (s_reg.st)
      fdsa_pkg::ST_RUN: begin
        if (latch_flt) begin
          s_next.st = fdsa_pkg::ST_LATCH;
          s_next.cls = latch_cls;
          s_next.det = latch_det;
        end else if (fault_sync) begin
          s_next.st = fdsa_pkg::ST_RECOV;
          s_next.cls = fdsa_pkg::CLS_SYNC;
          s_next.det = fdsa_pkg::DET_NONE;
          s_next.wait_ms = 16'h0000;
        end else if (hot && s_reg.hot_ms == DERATE_LAST) begin
          s_next.st = fdsa_pkg::ST_HOT;
          s_next.cls = fdsa_pkg::CLS_EXT;
          s_next.det = fdsa_pkg::DET_OVT;
        end else begin
          s_next.cls = fdsa_pkg::CLS_NONE;
          s_next.det = fdsa_pkg::DET_NONE;
        end
      end
      fdsa_pkg::ST_LATCH: begin
        // a memory or short fault still present in the reset cycle keeps the latch
        if (reset_cmd && !fault_mem && !fault_short) begin
          s_next.st = fdsa_pkg::ST_RUN;
          s_next.cls = fdsa_pkg::CLS_NONE;
          s_next.det = fdsa_pkg::DET_NONE;
        end
      end
      fdsa_pkg::ST_RECOV: begin
        if (latch_flt) begin
          s_next.st = fdsa_pkg::ST_LATCH;
          s_next.cls = latch_cls;
          s_next.det = latch_det;
        end else if (s_reg.tick) begin
          if (s_reg.wait_ms == RESTART_LAST) begin
            s_next.st = fdsa_pkg::ST_RUN;
            s_next.cls = fdsa_pkg::CLS_NONE;
          end else begin
            s_next.wait_ms = s_reg.wait_ms + 16'h0001;
          end
        end
      end
      fdsa_pkg::ST_HOT: begin
        if (latch_flt) begin
          s_next.st = fdsa_pkg::ST_LATCH;
          s_next.cls = latch_cls;
          s_next.det = latch_det;
        end else if (temperature < fdsa_pkg::TEMP_LIMIT) begin
          s_next.st = fdsa_pkg::ST_RUN;
          s_next.cls = fdsa_pkg::CLS_NONE;
          s_next.det = fdsa_pkg::DET_NONE;
        end
      end
      default: begin
        s_next.st = fdsa_pkg::ST_RUN;
      end
    endcase

    s_next.fan_run = (s_next.st == fdsa_pkg::ST_RUN);

    // reference restarts at minimum, then moves 1 rpm per ms
    // the start cycle reloads too, else the ramp would begin from the reset value
    if (!s_next.fan_run || !s_reg.fan_run) begin
      s_next.spd_ref = min_speed;
    end else if (s_reg.tick) begin
      if (s_reg.spd_ref < tgt) begin
        s_next.spd_ref = s_reg.spd_ref + 16'h0001;
      end else if (s_reg.spd_ref > tgt) begin
        s_next.spd_ref = s_reg.spd_ref - 16'h0001;
      end
    end

    // alarm visibility on led and digital output
    s_next.led = !s_reg.slot[0] && (s_reg.slot[3:1] < blinks(s_next.cls));
    s_next.dout = (dout_mode == fdsa_pkg::DOUT_ALARM) && (s_next.cls != 3'h0);

    // read-only input registers; writes do not exist on this port
    if (rd_en) begin
      s_next.rd_valid = 1'b1;
      case (rd_addr)
        fdsa_pkg::IDX_FW:      s_next.rd_data = fdsa_pkg::FW_REVISION;
        fdsa_pkg::IDX_ID:      s_next.rd_data = fdsa_pkg::DRIVER_ID;
        fdsa_pkg::IDX_SPD_REF: s_next.rd_data = s_reg.spd_ref;
        fdsa_pkg::IDX_SPEED:   s_next.rd_data = clamp(speed_meas, max_speed);
        fdsa_pkg::IDX_BUS_V:   s_next.rd_data = driver_on ? bus_voltage : 16'h0000;
        fdsa_pkg::IDX_CLASS:   s_next.rd_data = {13'h0000, s_reg.cls};
        fdsa_pkg::IDX_CURRENT: s_next.rd_data = clamp(current_peak, max_current);
        fdsa_pkg::IDX_VOLTAGE: s_next.rd_data = clamp(voltage_peak, fdsa_pkg::VOLT_MAX);
        fdsa_pkg::IDX_ANALOG:  s_next.rd_data = clamp(analog_in, fdsa_pkg::ANALOG_MAX);
        fdsa_pkg::IDX_TEMP:    s_next.rd_data = temperature;
        fdsa_pkg::IDX_DETAIL:  s_next.rd_data = {8'h00, s_reg.det};
        fdsa_pkg::IDX_POWER:   s_next.rd_data = clamp(power_meas, max_power);
        default: begin
          s_next.rd_data = 16'h0000;
          s_next.rd_err = 1'b1;
        end
      endcase
    end
  end

  // reset stands for a power cycle, so it also drops any latched stop
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data      = s_reg.rd_data;
  assign rd_valid     = s_reg.rd_valid;
  assign rd_err       = s_reg.rd_err;
  assign fan_run      = s_reg.fan_run;
  assign derate       = s_reg.derate;
  assign led          = s_reg.led;
  assign dout         = s_reg.dout;
  assign fault_class  = s_reg.cls;
  assign fault_detail = s_reg.det;

  a_fw_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_FW |=> rd_valid && rd_data == fdsa_pkg::FW_REVISION)
    else $error("firmware revision read wrong");

  a_id_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_ID |=> rd_data == fdsa_pkg::DRIVER_ID && !rd_err)
    else $error("identity read wrong");

  a_ref_stopped: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) && !fan_run |-> s_reg.spd_ref == $past(min_speed))
    else $error("speed reference not at minimum while stopped");

  a_speed_bound: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_SPEED |=> rd_data <= $past(max_speed))
    else $error("measured speed above maximum");

  a_bus_off: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_BUS_V && !driver_on |=> rd_data == 16'h0000)
    else $error("bus voltage not zero with driver off");

  a_class_range: assert property (@(posedge mclk) disable iff (rst)
    fault_class <= fdsa_pkg::CLS_EXT && (fault_class == 3'h0 || !fan_run))
    else $error("fault class out of range");

  a_volt_limit: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_VOLTAGE |=> rd_data <= fdsa_pkg::VOLT_MAX)
    else $error("motor voltage above limit");

  a_hot_derate: assert property (@(posedge mclk) disable iff (rst)
    temperature > fdsa_pkg::TEMP_LIMIT |=> derate)
    else $error("no derating above limit");

  a_latch_stop: assert property (@(posedge mclk) disable iff (rst)
    (fault_mem || fault_short) |=> !fan_run ##1 (!fan_run || $past(reset_cmd)))
    else $error("latching fault did not halt fan");

  a_comm_code: assert property (@(posedge mclk) disable iff (rst)
    s_reg.st == fdsa_pkg::ST_RUN && comm_lost && !fault_mem && !fault_short
    |=> fault_detail == fdsa_pkg::DET_COMM && fault_class == fdsa_pkg::CLS_EXT)
    else $error("communication loss not reported");

  a_dout_alarm: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> dout == ($past(dout_mode) == fdsa_pkg::DOUT_ALARM && fault_class != 3'h0))
    else $error("digital output does not follow alarm");

  a_ref_start: assert property (@(posedge mclk) disable iff (rst)
    $rose(fan_run) |-> s_reg.spd_ref == $past(min_speed))
    else $error("speed reference not at minimum on start");

  a_class_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_CLASS |=> rd_data == {13'h0000, $past(fault_class)})
    else $error("fault class read wrong");

  a_detail_read: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_DETAIL |=> rd_data == {8'h00, $past(fault_detail)})
    else $error("fault detail read wrong");

  a_current_bound: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_CURRENT |=> rd_data <= $past(max_current))
    else $error("motor current above maximum");

  a_analog_limit: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_ANALOG |=> rd_data <= fdsa_pkg::ANALOG_MAX)
    else $error("analog level above limit");

  a_power_bound: assert property (@(posedge mclk) disable iff (rst)
    rd_en && rd_addr == fdsa_pkg::IDX_POWER |=> rd_data <= $past(max_power))
    else $error("absorbed power above maximum");

  a_hot_stop: assert property (@(posedge mclk) disable iff (rst)
    s_reg.st == fdsa_pkg::ST_HOT |-> !fan_run && fault_detail == fdsa_pkg::DET_OVT)
    else $error("overtemperature stop not reported");

  a_hot_clear: assert property (@(posedge mclk) disable iff (rst)
    s_reg.st == fdsa_pkg::ST_HOT && !latch_flt && temperature < fdsa_pkg::TEMP_LIMIT
    |=> fault_class == fdsa_pkg::CLS_NONE && fan_run)
    else $error("overtemperature alarm not cleared");

  a_recov_stop: assert property (@(posedge mclk) disable iff (rst)
    s_reg.st == fdsa_pkg::ST_RECOV |-> !fan_run && fault_class == fdsa_pkg::CLS_SYNC)
    else $error("self-recovering stop not shown");

  a_no_fault: assert property (@(posedge mclk) disable iff (rst)
    fan_run |-> fault_class == fdsa_pkg::CLS_NONE && fault_detail == fdsa_pkg::DET_NONE)
    else $error("fault code while running");

  a_sync_class: assert property (@(posedge mclk) disable iff (rst)
    s_reg.st == fdsa_pkg::ST_RUN && fault_sync && !latch_flt
    |=> fault_class == fdsa_pkg::CLS_SYNC && !fan_run)
    else $error("synchronism loss not classified");

  a_short_class: assert property (@(posedge mclk) disable iff (rst)
    fault_short && !fault_mem && s_reg.st != fdsa_pkg::ST_LATCH
    |=> fault_class == fdsa_pkg::CLS_SHORT)
    else $error("short circuit not classified");

  a_err_data: assert property (@(posedge mclk) disable iff (rst)
    rd_err |-> rd_valid && rd_data == 16'h0000)
    else $error("unmapped read not answered with zero");

  a_valid_pulse: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> rd_valid == $past(rd_en))
    else $error("read answer not one cycle after request");

endmodule
